// >>> pwse_exec.sv
// Executor for prefix, window, return, rotate, extend and skip instructions.
`timescale 1ns/1ps
`default_nettype none
`include "pwse_regs.svh"
module pwse_exec
    import pwse_pkg::*;
#(
    parameter int CWP_W = 5
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Instruction stream from fetch
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr,
    input  wire logic [15:0] next_instr,
    input  wire logic [31:0] pc,
    // Operand registers and flags
    input  wire logic [31:0] target_gpr,
    input  wire logic [31:0] return_link_reg,
    input  wire logic [31:0] frame_ptr,
    input  wire logic [31:0] stack_ptr,
    input  wire logic        carry_in,
    // Window limits
    input  wire logic [CWP_W-1:0] window_upper_bound,
    input  wire logic [CWP_W-1:0] window_lower_bound,
    // Control register read port
    output logic [10:0]      ctl_index,
    input  wire logic [31:0] ctl_data,
    // Results
    output logic             wr_en,
    output logic [4:0]       wr_reg,
    output logic [31:0]      wr_data,
    output logic             sp_wr_en,
    output logic [31:0]      new_stack_ptr,
    output logic [31:0]      new_frame_ptr,
    output logic             carry_wr_en,
    output logic             carry_out,
    output logic             pc_load,
    output logic [31:0]      next_pc,
    output logic             trap,
    output logic [5:0]       trap_num,
    output logic             cache_bypass,
    output logic             in_delay_slot,
    // Architectural state
    output logic [10:0]      prefix_k,
    output logic [CWP_W-1:0] current_window_pointer
);
    if (CWP_W < 1 || CWP_W > 8) begin : g_cwp_w_check
        $error("CWP_W out of range");
    end

    pwse_dec_if d ();

    pwse_decoder u_pwse_decoder (
        .instr      (instr),
        .next_instr (next_instr),
        .d          (d)
    );

    logic [10:0]      k_q;
    logic             bypass_q;
    logic             slot_q;
    logic [CWP_W-1:0] cwp_q;
    logic             skip_cond;

    function automatic logic [31:0] skip_step(input logic nxt_pfx);
        return nxt_pfx ? `PWSE_SKIP_PREFIX : `PWSE_SKIP_PLAIN;
    endfunction

    // ----------------------------------------------------------------
    // Prefix constant
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            k_q <= 11'h000;
        end else if (instr_valid) begin
            if (d.op == PWSE_PFX || d.op == PWSE_PFXB) begin
                k_q <= d.prefix_immediate_field; // RQ1
            end else begin
                k_q <= 11'h000; // RQ2
            end
        end
    end

    // Remembers that the previous instruction asked for cache bypass.
    always_ff @(posedge clk) begin
        if (reset) begin
            bypass_q <= 1'b0;
        end else if (instr_valid) begin
            bypass_q <= (d.op == PWSE_PFXB);
        end
    end

    // The bypass prefix is only legal before a load, so the next
    // instruction is taken to be that load.
    assign cache_bypass = bypass_q; // RQ4 RQ3

    // ----------------------------------------------------------------
    // Window pointer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cwp_q <= CWP_W'(`PWSE_CWP_RESET);
        end else if (instr_valid && d.op == PWSE_RESTORE) begin
            cwp_q <= cwp_q + 1'b1; // RQ7
        end else if (instr_valid && d.op == PWSE_SAVE) begin
            cwp_q <= cwp_q - 1'b1; // RQ8
        end
    end

    // ----------------------------------------------------------------
    // Delay slot tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            slot_q <= 1'b0;
        end else if (instr_valid) begin
            slot_q <= (d.op == PWSE_RET); // RQ11
        end
    end

    assign in_delay_slot          = slot_q;
    assign prefix_k               = k_q;
    assign current_window_pointer = cwp_q;
    assign ctl_index              = (k_q == 11'h000) ? `PWSE_CTL_STATUS : k_q; // RQ5 RQ6

    // ----------------------------------------------------------------
    // Combinational execute
    // ----------------------------------------------------------------
    always_comb begin
        skip_cond = 1'b0;
        case (d.op)
            PWSE_SKPCLR: skip_cond = ~target_gpr[d.bit_index_field]; // RQ16
            PWSE_SKPSET: skip_cond = target_gpr[d.bit_index_field];  // RQ17
            PWSE_SKPNZ:  skip_cond = |target_gpr;         // RQ18
            default:     skip_cond = 1'b0;
        endcase
    end

    always_comb begin
        wr_en         = 1'b0;
        wr_reg        = d.reg_a;
        wr_data       = 32'h00000000;
        sp_wr_en      = 1'b0;
        new_stack_ptr = 32'h00000000;
        new_frame_ptr = 32'h00000000;
        carry_wr_en   = 1'b0;
        carry_out     = carry_in;
        pc_load       = 1'b0;
        next_pc       = pc + `PWSE_STEP_PLAIN;
        trap          = 1'b0;
        trap_num      = 6'h00;
        if (instr_valid) begin
            case (d.op)
                PWSE_CONTROL_READ_OP: begin
                    wr_en   = 1'b1;
                    wr_data = ctl_data; // RQ5 RQ6
                end
                PWSE_RESTORE: begin
                    if (cwp_q == window_upper_bound) begin
                        trap     = 1'b1;
                        trap_num = `PWSE_TRAP_OVER; // RQ7
                    end
                end
                PWSE_SAVE: begin
                    sp_wr_en      = 1'b1;
                    new_stack_ptr = frame_ptr - {22'h0, d.frame_size_field, 2'h0}; // RQ9
                    new_frame_ptr = stack_ptr; // RQ9
                    if (cwp_q == window_lower_bound) begin
                        trap     = 1'b1;
                        trap_num = `PWSE_TRAP_UNDER; // RQ8
                    end
                end
                PWSE_RET: begin
                    pc_load = 1'b1;
                    next_pc = {return_link_reg[30:0], 1'b0}; // RQ10
                end
                PWSE_RLC: begin
                    wr_en       = 1'b1;
                    wr_data     = {target_gpr[30:0], carry_in}; // RQ12
                    carry_wr_en = 1'b1;
                    carry_out   = target_gpr[31]; // RQ12
                end
                PWSE_RRC: begin
                    wr_en       = 1'b1;
                    wr_data     = {carry_in, target_gpr[31:1]}; // RQ13
                    carry_wr_en = 1'b1;
                    carry_out   = target_gpr[0]; // RQ13
                end
                PWSE_HALFWORD_SIGN_EXTEND: begin
                    wr_en   = 1'b1;
                    wr_data = {{16{target_gpr[15]}}, target_gpr[15:0]}; // RQ14
                end
                PWSE_BYTE_SIGN_EXTEND: begin
                    wr_en   = 1'b1;
                    wr_data = {{24{target_gpr[7]}}, target_gpr[7:0]}; // RQ15
                end
                PWSE_SKPCLR, PWSE_SKPSET, PWSE_SKPNZ: begin
                    if (skip_cond) begin
                        pc_load = 1'b1;
                        next_pc = pc + skip_step(d.next_is_prefix); // RQ19
                    end
                end
                default: begin
                    wr_en = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_k_cleared;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op != PWSE_PFX && d.op != PWSE_PFXB) |=> (k_q == 11'h000);
    endproperty
    a_k_cleared: assert property (p_k_cleared) else $error("prefix constant not cleared"); // RQ2

    property p_k_loaded;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_PFXB) |=> (k_q == $past(instr[10:0]) && cache_bypass);
    endproperty
    a_k_loaded: assert property (p_k_loaded) else $error("bypass prefix not loaded"); // RQ1

    property p_restore_inc;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_RESTORE) |=> (cwp_q == CWP_W'($past(cwp_q) + 1'b1));
    endproperty
    a_restore_inc: assert property (p_restore_inc) else $error("restore did not increment"); // RQ7

    property p_save_trap;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_SAVE && cwp_q == window_lower_bound)
            |-> (trap && trap_num == 6'h01);
    endproperty
    a_save_trap: assert property (p_save_trap) else $error("missing underflow trap"); // RQ8

    property p_save_sp;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_SAVE) |-> (frame_ptr - new_stack_ptr == {22'h0, instr[7:0], 2'h0});
    endproperty
    a_save_sp: assert property (p_save_sp) else $error("bad save stack pointer"); // RQ9

    property p_ret_target;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_RET) |-> (pc_load && next_pc[0] == 1'b0
            && next_pc[31:1] == return_link_reg[30:0]);
    endproperty
    a_ret_target: assert property (p_ret_target) else $error("bad return target"); // RQ10

    property p_rlc;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_RLC) |-> (carry_out == target_gpr[31] && wr_data[0] == carry_in);
    endproperty
    a_rlc: assert property (p_rlc) else $error("bad rotate left"); // RQ12

    property p_skip_step;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_SKPNZ && target_gpr != 32'h0)
            |-> (next_pc - pc == (d.next_is_prefix ? 32'h6 : 32'h4));
    endproperty
    a_skip_step: assert property (p_skip_step) else $error("bad skip distance"); // RQ18

    property p_bypass_clear;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op != PWSE_PFXB) |=> !cache_bypass;
    endproperty
    a_bypass_clear: assert property (p_bypass_clear) else $error("stale cache bypass"); // RQ4

    property p_control_read_op_status;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_CONTROL_READ_OP && k_q == 11'h000)
            |-> (wr_en && ctl_index == 11'h000);
    endproperty
    a_control_read_op_status: assert property (p_control_read_op_status) else $error("bad status read"); // RQ5

    property p_control_read_op_index;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_CONTROL_READ_OP && k_q != 11'h000)
            |-> (ctl_index == prefix_k && wr_data == ctl_data);
    endproperty
    a_control_read_op_index: assert property (p_control_read_op_index) else $error("bad indexed read"); // RQ6

    property p_restore_trap;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_RESTORE)
            |-> (trap == (cwp_q == window_upper_bound) && (!trap || trap_num == 6'h02));
    endproperty
    a_restore_trap: assert property (p_restore_trap) else $error("bad overflow trap"); // RQ7

    property p_save_dec;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_SAVE) |=> (cwp_q == CWP_W'($past(cwp_q) - 1'b1));
    endproperty
    a_save_dec: assert property (p_save_dec) else $error("save did not decrement"); // RQ8

    property p_save_fp;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_SAVE) |-> (sp_wr_en && new_frame_ptr == stack_ptr);
    endproperty
    a_save_fp: assert property (p_save_fp) else $error("bad save frame pointer"); // RQ9

    property p_ret_slot;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_RET) |=> in_delay_slot;
    endproperty
    a_ret_slot: assert property (p_ret_slot) else $error("delay slot not marked"); // RQ11

    property p_rrc;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_RRC) |-> (carry_wr_en && carry_out == target_gpr[0]
            && wr_data[31] == carry_in && wr_data[30:0] == target_gpr[31:1]);
    endproperty
    a_rrc: assert property (p_rrc) else $error("bad rotate right"); // RQ13

    property p_halfword_sign_extend;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_HALFWORD_SIGN_EXTEND)
            |-> (!carry_wr_en && $signed(wr_data) == $signed(target_gpr[15:0]));
    endproperty
    a_halfword_sign_extend: assert property (p_halfword_sign_extend) else $error("bad halfword extend"); // RQ14

    property p_byte_sign_extend;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_BYTE_SIGN_EXTEND)
            |-> (!carry_wr_en && $signed(wr_data) == $signed(target_gpr[7:0]));
    endproperty
    a_byte_sign_extend: assert property (p_byte_sign_extend) else $error("bad byte extend"); // RQ15

    property p_skip_clr;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_SKPCLR) |-> (pc_load == !target_gpr[instr[9:5]]);
    endproperty
    a_skip_clr: assert property (p_skip_clr) else $error("bad skip on clear"); // RQ16

    property p_skip_set;
        @(posedge clk) disable iff (reset)
        (instr_valid && d.op == PWSE_SKPSET) |-> (pc_load == target_gpr[instr[9:5]]);
    endproperty
    a_skip_set: assert property (p_skip_set) else $error("bad skip on set"); // RQ17

    property p_skip_pfx;
        @(posedge clk) disable iff (reset)
        (instr_valid && pc_load && d.op inside {PWSE_SKPCLR, PWSE_SKPSET, PWSE_SKPNZ})
            |-> (next_pc == pc + ((next_instr[15:12] == 4'h9) ? 32'h6 : 32'h4));
    endproperty
    a_skip_pfx: assert property (p_skip_pfx) else $error("bad skip over prefix"); // RQ19
endmodule
`default_nettype wire

// >>> pwse_regs.svh
// Constants for the prefix, window and skip execution block.
// What this block does
// [RQ1] Bypass prefix loads 11-bit field into constant.
// [RQ2] Constant clears after every non-prefix instruction.
// [RQ3] Software puts bypass prefix only before loads.
// [RQ4] Load after bypass prefix skips data cache.
// [RQ5] Unprefixed control read returns status register.
// [RQ6] Prefixed control read returns indexed control register.
// [RQ7] Restore increments pointer, overflow trap 2.
// [RQ8] Save decrements pointer, underflow trap 1.
// [RQ9] Save sets stack from frame minus 4*size.
// [RQ10] Return jumps to link register shifted left.
// [RQ11] Delay slot executes before return target.
// [RQ12] Rotate left: carry takes bit 31.
// [RQ13] Rotate right: carry takes bit 0.
// [RQ14] Halfword extend copies bit 15 upward.
// [RQ15] Byte extend copies bit 7 upward.
// [RQ16] Skip when selected bit is clear.
// [RQ17] Skip when selected bit is set.
// [RQ18] Skip when register is nonzero.
// [RQ19] Skip advances 6 over prefix, else 4.
`ifndef PWSE_REGS_SVH
`define PWSE_REGS_SVH
`define PWSE_OP_PFX       5'h13
`define PWSE_OP_PFXB      5'h12
`define PWSE_OP6_SKPCLR   6'h14
`define PWSE_OP6_SKPSET   6'h15
`define PWSE_OP5_SAVE     5'h0F
`define PWSE_OP11_CONTROL_READ_OP   11'h3F9
`define PWSE_OP11_RLC     11'h3E5
`define PWSE_OP11_RRC     11'h3E6
`define PWSE_OP11_HALFWORD_SIGN_EXTEND  11'h3E4
`define PWSE_OP11_BYTE_SIGN_EXTEND   11'h3E3
`define PWSE_OP11_SKPNZ   11'h3FA
`define PWSE_OP16_RESTORE 16'h7DA0
`define PWSE_OP16_RET     16'h7FDF
`define PWSE_TRAP_UNDER   6'h01
`define PWSE_TRAP_OVER    6'h02
`define PWSE_CTL_STATUS   11'h000
`define PWSE_STEP_PLAIN   32'h00000002
`define PWSE_SKIP_PLAIN   32'h00000004
`define PWSE_SKIP_PREFIX  32'h00000006
`define PWSE_CWP_RESET    5'h00
`endif

// >>> pwse_pkg.sv
// Types shared by the execution block.
package pwse_pkg;
    typedef enum logic [3:0] {
        PWSE_NONE, PWSE_PFX, PWSE_PFXB, PWSE_CONTROL_READ_OP, PWSE_RESTORE, PWSE_SAVE,
        PWSE_RET, PWSE_RLC, PWSE_RRC, PWSE_HALFWORD_SIGN_EXTEND, PWSE_BYTE_SIGN_EXTEND,
        PWSE_SKPCLR, PWSE_SKPSET, PWSE_SKPNZ
    } pwse_op_t;
endpackage

// >>> pwse_dec_if.sv
// Decoded instruction carrier between decoder and executor.
`timescale 1ns/1ps
`default_nettype none
interface pwse_dec_if;
    import pwse_pkg::*;
    pwse_op_t    op;
    logic [10:0] prefix_immediate_field;
    logic [7:0]  frame_size_field;
    logic [4:0]  bit_index_field;
    logic [4:0]  reg_a;
    logic        next_is_prefix;
    modport dec (output op, prefix_immediate_field, frame_size_field, bit_index_field, reg_a, next_is_prefix);
    modport exe (input op, prefix_immediate_field, frame_size_field, bit_index_field, reg_a, next_is_prefix);
endinterface
`default_nettype wire

// >>> pwse_decoder.sv
// Instruction decoder for the prefix, window and skip group.
`timescale 1ns/1ps
`default_nettype none
`include "pwse_regs.svh"
module pwse_decoder
    import pwse_pkg::*;
(
    // Instruction halfwords
    input  wire logic [15:0] instr,
    input  wire logic [15:0] next_instr,
    // Decoded output
    pwse_dec_if.dec          d
);
    function automatic logic is_prefix(input logic [15:0] w);
        return w[15:11] == `PWSE_OP_PFX || w[15:11] == `PWSE_OP_PFXB;
    endfunction

    always_comb begin
        d.op = PWSE_NONE;
        if (instr[15:11] == `PWSE_OP_PFX) begin
            d.op = PWSE_PFX;
        end else if (instr[15:11] == `PWSE_OP_PFXB) begin
            d.op = PWSE_PFXB;
        end else if (instr == `PWSE_OP16_RESTORE) begin
            d.op = PWSE_RESTORE;
        end else if (instr == `PWSE_OP16_RET) begin
            d.op = PWSE_RET;
        end else if (instr[15:11] == `PWSE_OP5_SAVE && instr[10:8] == 3'h0) begin
            d.op = PWSE_SAVE;
        end else if (instr[15:10] == `PWSE_OP6_SKPCLR) begin
            d.op = PWSE_SKPCLR;
        end else if (instr[15:10] == `PWSE_OP6_SKPSET) begin
            d.op = PWSE_SKPSET;
        end else begin
            case (instr[15:5])
                `PWSE_OP11_CONTROL_READ_OP:  d.op = PWSE_CONTROL_READ_OP;
                `PWSE_OP11_RLC:    d.op = PWSE_RLC;
                `PWSE_OP11_RRC:    d.op = PWSE_RRC;
                `PWSE_OP11_HALFWORD_SIGN_EXTEND: d.op = PWSE_HALFWORD_SIGN_EXTEND;
                `PWSE_OP11_BYTE_SIGN_EXTEND:  d.op = PWSE_BYTE_SIGN_EXTEND;
                `PWSE_OP11_SKPNZ:  d.op = PWSE_SKPNZ;
                default:           d.op = PWSE_NONE;
            endcase
        end
    end

    assign d.prefix_immediate_field          = instr[10:0];
    assign d.frame_size_field           = instr[7:0];
    assign d.bit_index_field           = instr[9:5];
    assign d.reg_a          = instr[4:0];
    assign d.next_is_prefix = is_prefix(next_instr);
endmodule
`default_nettype wire

// >>> pwse_prog.sv
// Instruction memory model that feeds halfwords to the executor by program counter.
`timescale 1ns/1ps
`default_nettype none
module pwse_prog (
    // Fetch address
    input  wire logic [31:0] pc,
    // Current and following halfword
    output logic      [15:0] instr,
    output logic      [15:0] next_instr
);
    // ------------------------------------------------------------
    // Program store
    // ------------------------------------------------------------
    // The loaded program puts a bypass prefix only directly ahead of a word load.
    logic [15:0] mem [0:63];
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 16'h3000;
        end
    end
    assign instr      = mem[pc[6:1]];
    assign next_instr = mem[pc[6:1] + 6'h01];
endmodule
`default_nettype wire

// >>> prefix_window_skip_exec_bench.sv
// Self-checking bench for the prefix, window, return, rotate and skip executor.
`timescale 1ns/1ps
`default_nettype none
`include "pwse_regs.svh"
module prefix_window_skip_exec_bench;
    import pwse_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int CW = 5;
    localparam int NW = 57 + CW;
    localparam logic [15:0] WORD_LOAD = 16'h5800;
    localparam logic [7:0]  F_WR = 8'h80;
    localparam logic [7:0]  F_CW = 8'h40;
    localparam logic [7:0]  F_CO = 8'h20;
    localparam logic [7:0]  F_PL = 8'h10;
    localparam logic [7:0]  F_TR = 8'h08;
    localparam logic [7:0]  F_SP = 8'h04;
    logic clk, reset, instr_valid, carry_in, wr_en, sp_wr_en, carry_wr_en, carry_out;
    logic pc_load, trap, cache_bypass, in_delay_slot;
    logic [15:0] instr, next_instr;
    logic [31:0] pc, target_gpr, return_link_reg, frame_ptr, stack_ptr, ctl_data, wr_data;
    logic [31:0] new_stack_ptr, new_frame_ptr, next_pc, r;
    logic [CW-1:0] window_upper_bound, window_lower_bound, current_window_pointer, cwp_e;
    logic [10:0] ctl_index, prefix_k, k_e;
    logic [4:0]  wr_reg;
    logic [5:0]  trap_num;
    logic        byp_e, slot_e;
    logic [15:0] ins_q [$];
    logic [31:0] ra_q [$];
    logic [NW-1:0] ex_q [$];
    logic [NW-1:0] exp_q [$];
    logic [NW-1:0] seen_v;
    int fail_count, checks_done;
    integer seed;
    assign ctl_data = ~{21'h0, ctl_index};
    always #20 clk = ~clk;
    // ------------------------------------------------------------
    // Design and program store
    // ------------------------------------------------------------
    pwse_exec #(.CWP_W(CW)) u_pwse_exec (.clk(clk), .reset(reset), .instr_valid(instr_valid),
        .instr(instr), .next_instr(next_instr), .pc(pc), .target_gpr(target_gpr),
        .return_link_reg(return_link_reg), .frame_ptr(frame_ptr), .stack_ptr(stack_ptr),
        .carry_in(carry_in), .window_upper_bound(window_upper_bound),
        .window_lower_bound(window_lower_bound), .ctl_index(ctl_index), .ctl_data(ctl_data),
        .wr_en(wr_en), .wr_reg(wr_reg), .wr_data(wr_data), .sp_wr_en(sp_wr_en),
        .new_stack_ptr(new_stack_ptr), .new_frame_ptr(new_frame_ptr),
        .carry_wr_en(carry_wr_en), .carry_out(carry_out), .pc_load(pc_load), .next_pc(next_pc),
        .trap(trap), .trap_num(trap_num), .cache_bypass(cache_bypass),
        .in_delay_slot(in_delay_slot), .prefix_k(prefix_k),
        .current_window_pointer(current_window_pointer));
    pwse_prog u_pwse_prog (.pc(pc), .instr(instr), .next_instr(next_instr));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [NW-1:0] seen, input logic [NW-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [31:0] pn(input int n);
        return 32'(2 * ins_q.size() + n);
    endfunction
    task automatic put(input logic [15:0] ins, input logic [31:0] ra, input logic [7:0] fl,
                       input logic [5:0] tn, input logic [31:0] v);
        u_pwse_prog.mem[ins_q.size()] = ins;
        ins_q.push_back(ins);
        ra_q.push_back(ra);
        ex_q.push_back({fl | {6'h00, byp_e, slot_e}, tn, k_e, cwp_e, v});
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic run;
        int w;
        for (int i = 0; i < ins_q.size(); i++) begin
            @(posedge clk);
            #1;
            pc = 32'(2 * i);
            target_gpr = ra_q[i];
            instr_valid = 1'b1;
            exp_q.push_back(ex_q[i]);
        end
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        ins_q.delete();
        ra_q.delete();
        ex_q.delete();
        for (w = 0; w < 10 && exp_q.size() != 0; w++) @(negedge clk);
        if (exp_q.size() != 0) begin
            fail_count++;
            end_sim();
        end
    endtask
    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (instr_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("MISMATCH result expected none seen a result");
            end else begin
                seen_v = {wr_en, carry_wr_en, carry_out & carry_wr_en, pc_load, trap,
                    sp_wr_en, cache_bypass, in_delay_slot, trap ? trap_num : 6'h00, prefix_k,
                    current_window_pointer, pc_load ? next_pc : sp_wr_en ? new_stack_ptr :
                    wr_en ? wr_data : next_pc};
                chk("result", seen_v, exp_q.pop_front());
                if (wr_en === 1'b1)
                    chk("wr_reg", NW'(wr_reg), NW'(instr[4:0]));
                if (sp_wr_en === 1'b1)
                    chk("new_frame_ptr", NW'(new_frame_ptr), NW'(stack_ptr));
            end
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 32'h5C66;
        clk = 1'b0;
        reset = 1'b1;
        instr_valid = 1'b0;
        pc = 32'h0;
        target_gpr = 32'h0;
        carry_in = 1'b0;
        return_link_reg = $random(seed);
        frame_ptr = $random(seed);
        stack_ptr = $random(seed);
        window_upper_bound = 5'h01;
        window_lower_bound = 5'h00;
        {fail_count, checks_done, k_e, cwp_e, byp_e, slot_e} = '0;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        r = $random(seed);
        put({`PWSE_OP_PFX, 11'h002}, 0, 0, 6'h00, pn(2));
        k_e = 11'h002;
        put({`PWSE_OP11_CONTROL_READ_OP, 5'h07}, 0, F_WR, 6'h00, ~32'h2);
        k_e = 11'h000;
        put({`PWSE_OP11_CONTROL_READ_OP, 5'h03}, 0, F_WR, 6'h00, ~32'h0);
        put({`PWSE_OP_PFX, r[10:0]}, 0, 0, 6'h00, pn(2));
        k_e = r[10:0];
        put({`PWSE_OP11_CONTROL_READ_OP, 5'h01}, 0, F_WR, 6'h00, ~{21'h0, r[10:0]});
        k_e = 11'h000;
        put({`PWSE_OP_PFXB, r[21:11]}, 0, 0, 6'h00, pn(2));
        k_e = r[21:11];
        byp_e = 1'b1;
        put(WORD_LOAD, 0, 0, 6'h00, pn(2));
        {k_e, byp_e} = '0;
        put({`PWSE_OP11_CONTROL_READ_OP, 5'h02}, 0, F_WR, 6'h00, ~32'h0);
        put(`PWSE_OP16_RESTORE, 0, 0, 6'h00, pn(2));
        cwp_e = 5'h01;
        put(`PWSE_OP16_RESTORE, 0, F_TR, 6'h02, pn(2));
        cwp_e = 5'h02;
        for (int i = 0; i < 3; i++) begin
            r = (i == 2) ? 32'hFF : $random(seed);
            put({`PWSE_OP5_SAVE, 3'h0, r[7:0]}, 0, (i == 2) ? F_SP | F_TR : F_SP,
                (i == 2) ? 6'h01 : 6'h00, frame_ptr - {22'h0, r[7:0], 2'b00});
            cwp_e = cwp_e - 1'b1;
        end
        put({`PWSE_OP11_BYTE_SIGN_EXTEND, 5'h00}, 32'h80, F_WR, 6'h00, 32'hFFFFFF80);
        run();
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            carry_in = i[0];
            put({`PWSE_OP11_RLC, 5'h04}, r, F_WR | F_CW | (r[31] ? F_CO : 8'h00), 6'h00,
                {r[30:0], carry_in});
            put({`PWSE_OP11_RRC, 5'h04}, r, F_WR | F_CW | (r[0] ? F_CO : 8'h00), 6'h00,
                {carry_in, r[31:1]});
            put({`PWSE_OP11_HALFWORD_SIGN_EXTEND, 5'h04}, r, F_WR, 6'h00, {{16{r[15]}}, r[15:0]});
            put({`PWSE_OP11_BYTE_SIGN_EXTEND, 5'h04}, r, F_WR, 6'h00, {{24{r[7]}}, r[7:0]});
            run();
        end
        // A reset in mid-run must bring the window pointer back to its reset value.
        @(posedge clk);
        #1;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        cwp_e = '0;
        r = $random(seed);
        put({`PWSE_OP6_SKPCLR, r[4:0], 5'h02}, ~(32'h1 << r[4:0]), F_PL, 6'h00, pn(4));
        put({`PWSE_OP6_SKPSET, r[4:0], 5'h02}, ~(32'h1 << r[4:0]), 0, 6'h00, pn(2));
        put({`PWSE_OP6_SKPSET, r[9:5], 5'h02}, 32'h1 << r[9:5], F_PL, 6'h00, pn(6));
        put({`PWSE_OP_PFX, 11'h003}, 0, 0, 6'h00, pn(2));
        k_e = 11'h003;
        put({`PWSE_OP11_CONTROL_READ_OP, 5'h05}, 0, F_WR, 6'h00, ~32'h3);
        k_e = 11'h000;
        put({`PWSE_OP11_SKPNZ, 5'h02}, 0, 0, 6'h00, pn(2));
        put({`PWSE_OP11_SKPNZ, 5'h02}, r | 32'h1, F_PL, 6'h00, pn(6));
        put({`PWSE_OP_PFXB, 11'h000}, 0, 0, 6'h00, pn(2));
        byp_e = 1'b1;
        put(WORD_LOAD, 0, 0, 6'h00, pn(2));
        byp_e = 1'b0;
        put(`PWSE_OP16_RET, 0, F_PL, 6'h00, return_link_reg << 1);
        slot_e = 1'b1;
        put(16'h3000, 0, 0, 6'h00, pn(2));
        slot_e = 1'b0;
        put(16'h3000, 0, 0, 6'h00, pn(2));
        run();
        end_sim();
    end
endmodule
`default_nettype wire
